// ### src/tsf_core.sv
// table statistics and piecewise linear lookup datapath: maximum, minimum,
// average, lookup and magnitude. assumes the sequencer answers a table read
// with data in the cycle after tbl_rd_req, addressed relative to the operand.
`timescale 1ns/10ps

// How it works
// - max scan writes value and position
// - min scan writes value and position
// - table words compared as signed
// - tied maximum reports lowest position
// - tied minimum reports lowest position
// - index destination drops the position
// - average of n words written
// - lookup evaluates f(x) over 2n words
// - first n x, next n y
// - interpolate between neighbouring pairs
// - below first breakpoint gives first y
// - above last breakpoint gives last y
// - lookup values signed full range
// - magnitude writes absolute source value
// - most negative saturates to largest positive
module tsf_core #(
    parameter int DATA_W = 16,
    parameter int CNT_W  = 7
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // instruction request
    input  wire logic             req_valid,
    input  wire tsf_pkg::tsf_req_s req,
    output logic                  busy_r,
    // table read port
    output logic                  tbl_rd_req_r,
    output logic [CNT_W-1:0]      tbl_rd_addr_r,
    input  wire logic [DATA_W-1:0] tbl_rd_data,
    // result
    output logic                  done_r,
    output tsf_pkg::tsf_res_s     res_r
);

    localparam int SUM_W = 23;

    tsf_pkg::tsf_state_e state_r;
    tsf_pkg::tsf_state_e state_nxt;
    tsf_pkg::tsf_phase_e phase_r;
    tsf_pkg::tsf_phase_e phase_nxt;
    tsf_pkg::tsf_req_s   op_r;
    tsf_pkg::tsf_res_s   res_nxt;
    logic [CNT_W-1:0]    idx_r;
    logic [CNT_W-1:0]    idx_nxt;
    logic [CNT_W-1:0]    addr_nxt;
    logic                single_r;
    logic                single_nxt;
    logic [DATA_W-1:0]   xlo_r;
    logic [DATA_W-1:0]   xhi_r;
    logic [DATA_W-1:0]   ylo_r;
    logic [DATA_W-1:0]   yhi_r;

    logic signed [DATA_W-1:0] max_val;
    logic signed [DATA_W-1:0] min_val;
    logic [CNT_W-1:0]         max_pos;
    logic [CNT_W-1:0]         min_pos;
    logic signed [SUM_W-1:0]  sum;

    // request decode
    wire take_req  = (state_r == tsf_pkg::ST_IDLE) && req_valid;
    wire is_stats  = (op_r.op == tsf_pkg::OP_MAX) || (op_r.op == tsf_pkg::OP_MIN)
                   || (op_r.op == tsf_pkg::OP_AVG);
    wire is_lookup = (op_r.op == tsf_pkg::OP_LOOKUP);
    wire is_search = (op_r.op == tsf_pkg::OP_MAX) || (op_r.op == tsf_pkg::OP_MIN);
    wire in_cap    = (state_r == tsf_pkg::ST_CAP);
    wire last_idx  = (idx_r == op_r.cnt - tsf_pkg::STEP_ONE);
    wire scan_word = in_cap && is_stats;

    wire x_below   = $signed(op_r.x) < $signed(tbl_rd_data);

    // y values follow the n x words
    wire [CNT_W-1:0] y_first = op_r.cnt;
    wire [CNT_W-1:0] y_last  = op_r.cnt + op_r.cnt - tsf_pkg::STEP_ONE;
    wire [CNT_W-1:0] y_lo    = op_r.cnt + idx_r - tsf_pkg::STEP_ONE;

    // 34-bit product, division truncates toward zero
    wire signed [16:0] dx     = $signed({op_r.x[15], op_r.x}) - $signed({xlo_r[15], xlo_r});
    wire signed [16:0] dy     = $signed({yhi_r[15], yhi_r}) - $signed({ylo_r[15], ylo_r});
    wire signed [16:0] den    = $signed({xhi_r[15], xhi_r}) - $signed({xlo_r[15], xlo_r});
    wire signed [16:0] den_sf = (den == 17'sh00000) ? 17'sh00001 : den;
    wire signed [33:0] prod   = dx * dy;
    wire signed [33:0] quot   = prod / 34'(den_sf);
    wire signed [16:0] interp = $signed({ylo_r[15], ylo_r}) + $signed(quot[16:0]);

    // single value covers both clamped ends
    // last y for x at or past last breakpoint
    wire [DATA_W-1:0] lookup_val = single_r ? yhi_r : interp[15:0];

    wire signed [SUM_W-1:0] avg = sum / $signed({16'h0000, op_r.cnt});

    // saturate the one value with no positive twin
    wire [DATA_W-1:0] mag_val = (op_r.x == tsf_pkg::MOST_NEG) ? tsf_pkg::SAT_POS :
                                op_r.x[15] ? (~op_r.x + tsf_pkg::WORD_ONE) : op_r.x;

    // result value selection
    wire [DATA_W-1:0] op_val =
        (op_r.op == tsf_pkg::OP_MAX)    ? max_val :
        (op_r.op == tsf_pkg::OP_MIN)    ? min_val :
        (op_r.op == tsf_pkg::OP_AVG)    ? avg[15:0] :
        (op_r.op == tsf_pkg::OP_LOOKUP) ? lookup_val : mag_val;
    wire [CNT_W-1:0] op_pos = (op_r.op == tsf_pkg::OP_MIN) ? min_pos : max_pos;

    always_comb begin
        res_nxt          = res_r;
        res_nxt.out_cond = op_r.cond;
        res_nxt.wr_value = op_r.cond;
        res_nxt.wr_pos   = op_r.cond && is_search && !op_r.dest_index;
        if (op_r.cond) begin
            res_nxt.value = op_val;
            res_nxt.pos   = {9'h000, op_pos};
        end
    end

    // sequencing: one table read per RD/CAP pair
    always_comb begin
        state_nxt  = state_r;
        phase_nxt  = phase_r;
        idx_nxt    = idx_r;
        addr_nxt   = tbl_rd_addr_r;
        single_nxt = single_r;
        case (state_r)
            tsf_pkg::ST_IDLE: begin
                idx_nxt    = tsf_pkg::ADDR_ZERO;
                addr_nxt   = tsf_pkg::ADDR_ZERO;
                phase_nxt  = tsf_pkg::PH_SCAN;
                single_nxt = 1'b0;
                if (req_valid) begin
                    if (!req.cond || req.op == tsf_pkg::OP_MAG) begin
                        state_nxt = tsf_pkg::ST_FIN;
                    end else begin
                        state_nxt = tsf_pkg::ST_RD;
                    end
                end
            end
            tsf_pkg::ST_RD: begin
                state_nxt = tsf_pkg::ST_CAP;
            end
            tsf_pkg::ST_CAP: begin
                state_nxt = tsf_pkg::ST_RD;
                if (is_stats) begin
                    if (last_idx) begin
                        state_nxt = tsf_pkg::ST_FIN;
                    end else begin
                        idx_nxt  = idx_r + tsf_pkg::STEP_ONE;
                        addr_nxt = idx_r + tsf_pkg::STEP_ONE;
                    end
                end else if (phase_r == tsf_pkg::PH_SCAN) begin
                    if (x_below && idx_r == tsf_pkg::ADDR_ZERO) begin
                        single_nxt = 1'b1;
                        addr_nxt   = y_first;
                        phase_nxt  = tsf_pkg::PH_YHI;
                    end else if (x_below) begin
                        addr_nxt  = y_lo;
                        phase_nxt = tsf_pkg::PH_YLO;
                    end else if (last_idx) begin
                        single_nxt = 1'b1;
                        addr_nxt   = y_last;
                        phase_nxt  = tsf_pkg::PH_YHI;
                    end else begin
                        idx_nxt  = idx_r + tsf_pkg::STEP_ONE;
                        addr_nxt = idx_r + tsf_pkg::STEP_ONE;
                    end
                end else if (phase_r == tsf_pkg::PH_YLO) begin
                    addr_nxt  = tbl_rd_addr_r + tsf_pkg::STEP_ONE;
                    phase_nxt = tsf_pkg::PH_YHI;
                end else begin
                    state_nxt = tsf_pkg::ST_FIN;
                end
            end
            tsf_pkg::ST_FIN: begin
                state_nxt = tsf_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = tsf_pkg::ST_IDLE;
            end
        endcase
    end

    // state and counters
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= tsf_pkg::ST_IDLE;
            phase_r  <= tsf_pkg::PH_SCAN;
            idx_r    <= '0;
            single_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            phase_r  <= phase_nxt;
            idx_r    <= idx_nxt;
            single_r <= single_nxt;
        end
    end

    // latched instruction, held until the next request
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_r <= '0;
        end else if (take_req) begin
            op_r <= req;
        end
    end

    // lookup operands; xlo trails the scan by one breakpoint
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xlo_r <= '0;
            xhi_r <= '0;
            ylo_r <= '0;
            yhi_r <= '0;
        end else if (in_cap && is_lookup) begin
            if (phase_r == tsf_pkg::PH_SCAN && !x_below) xlo_r <= tbl_rd_data;
            if (phase_r == tsf_pkg::PH_SCAN && x_below)  xhi_r <= tbl_rd_data;
            if (phase_r == tsf_pkg::PH_YLO)              ylo_r <= tbl_rd_data;
            if (phase_r == tsf_pkg::PH_YHI)              yhi_r <= tbl_rd_data;
        end
    end

    // registered outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r        <= 1'b0;
            tbl_rd_req_r  <= 1'b0;
            tbl_rd_addr_r <= '0;
            done_r        <= 1'b0;
            res_r         <= '0;
        end else begin
            busy_r        <= (state_nxt != tsf_pkg::ST_IDLE);
            tbl_rd_req_r  <= (state_nxt == tsf_pkg::ST_RD);
            tbl_rd_addr_r <= addr_nxt;
            done_r        <= (state_r == tsf_pkg::ST_FIN);
            if (state_r == tsf_pkg::ST_FIN) res_r <= res_nxt;
        end
    end

    // max, min and sum accumulate as words arrive
    tsf_scan_unit #(
        .DATA_W (DATA_W),
        .POS_W  (CNT_W),
        .SUM_W  (SUM_W)
    ) u_scan (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .clear      (take_req),
        .word_valid (scan_word),
        .word       ($signed(tbl_rd_data)),
        .pos        (idx_r),
        .max_val_r  (max_val),
        .max_pos_r  (max_pos),
        .min_val_r  (min_val),
        .min_pos_r  (min_pos),
        .sum_r      (sum)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    cond_off_quiet_a: assert property (
        take_req && !req.cond |-> ##2 done_r && !res_r.out_cond && !res_r.wr_value)
        else $error("write or output on with condition off");
    cond_on_out_a: assert property (
        done_r && op_r.cond |-> res_r.out_cond && res_r.wr_value)
        else $error("output condition off after execution");
    mag_saturate_a: assert property (
        take_req && req.cond && req.op == tsf_pkg::OP_MAG && req.x == tsf_pkg::MOST_NEG
        |-> ##2 res_r.value == tsf_pkg::SAT_POS)
        else $error("most negative source not saturated");
    mag_positive_a: assert property (
        done_r && op_r.cond && op_r.op == tsf_pkg::OP_MAG |-> !res_r.value[15])
        else $error("magnitude result negative");
    pos_drop_a: assert property (
        done_r && op_r.dest_index |-> !res_r.wr_pos)
        else $error("position written to index destination");
    lookup_range_a: assert property (
        tbl_rd_req_r && is_lookup |-> tbl_rd_addr_r < op_r.cnt + op_r.cnt)
        else $error("lookup read outside its 2n words");
    read_answer_a: assert property (
        tbl_rd_req_r |=> state_r == tsf_pkg::ST_CAP && !tbl_rd_req_r)
        else $error("read not followed by capture");
    clamp_value_a: assert property (
        state_r == tsf_pkg::ST_FIN && is_lookup && op_r.cond && single_r
        |=> res_r.value == $past(yhi_r))
        else $error("clamped lookup not equal to end y");
    interp_between_a: assert property (
        state_r == tsf_pkg::ST_FIN && is_lookup && op_r.cond && !single_r
        && $signed(ylo_r) <= $signed(yhi_r)
        |=> $signed(res_r.value) >= $signed($past(ylo_r))
            && $signed(res_r.value) <= $signed($past(yhi_r)))
        else $error("interpolated value outside segment");

    search_done_c: cover property (done_r && is_search && res_r.wr_pos);
    lookup_interp_c: cover property (done_r && is_lookup && op_r.cond && !single_r);
    mag_sat_c: cover property (done_r && op_r.op == tsf_pkg::OP_MAG
                               && res_r.value == tsf_pkg::SAT_POS);

endmodule : tsf_core

// ### inc/tsf_pkg.sv
// shared constants, enumerations and carrier structs of the table statistics and
// function generator datapath; assumes a sequencer that resolves operand addresses.
package tsf_pkg;

    // word and table geometry
    localparam int DATA_W    = 16;
    localparam int CNT_W     = 7;
    localparam int ADDR_W    = 7;
    localparam int MAX_TABLE = 64;
    localparam int MAX_PAIRS = 32;

    // magnitude saturation corner
    localparam logic [15:0] MOST_NEG = 16'h8000;
    localparam logic [15:0] SAT_POS  = 16'h7FFF;
    localparam logic [15:0] WORD_ONE = 16'h0001;

    // address and count steps
    localparam logic [6:0] STEP_ONE = 7'h01;
    localparam logic [6:0] ADDR_ZERO = 7'h00;

    // operation codes
    typedef enum logic [2:0] {
        OP_MAX    = 3'h0,
        OP_MIN    = 3'h1,
        OP_AVG    = 3'h2,
        OP_LOOKUP = 3'h3,
        OP_MAG    = 3'h4
    } tsf_op_e;

    // sequencing states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RD   = 4'h2,
        ST_CAP  = 4'h4,
        ST_FIN  = 4'h8
    } tsf_state_e;

    // what the captured word is used for
    typedef enum logic [1:0] {
        PH_SCAN = 2'h0,
        PH_YLO  = 2'h1,
        PH_YHI  = 2'h2
    } tsf_phase_e;

    // one instruction from the sequencer
    typedef struct packed {
        tsf_op_e     op;
        logic        cond;
        logic        dest_index;
        logic [6:0]  cnt;
        logic [15:0] x;
    } tsf_req_s;

    // one instruction result
    typedef struct packed {
        logic        out_cond;
        logic        wr_value;
        logic        wr_pos;
        logic [15:0] value;
        logic [15:0] pos;
    } tsf_res_s;

endpackage : tsf_pkg

// ### src/tsf_scan_unit.sv
// running maximum, minimum and sum over a stream of signed table words.
// assumes one word per word_valid and a clear pulse before each new table.
`timescale 1ns/10ps

module tsf_scan_unit #(
    parameter int DATA_W = 16,
    parameter int POS_W  = 7,
    parameter int SUM_W  = 23
) (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    // word stream
    input  wire logic                     clear,
    input  wire logic                     word_valid,
    input  wire logic signed [DATA_W-1:0] word,
    input  wire logic [POS_W-1:0]         pos,
    // running results
    output logic signed [DATA_W-1:0]      max_val_r,
    output logic [POS_W-1:0]              max_pos_r,
    output logic signed [DATA_W-1:0]      min_val_r,
    output logic [POS_W-1:0]              min_pos_r,
    output logic signed [SUM_W-1:0]       sum_r
);

    logic first_r;

    // strict compare keeps first
    // strict compare keeps the earliest position on ties
    wire take_max = first_r || (word > max_val_r);
    wire take_min = first_r || (word < min_val_r);
    wire signed [SUM_W-1:0] word_ext = SUM_W'(word);

    // first word seeds both extremes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_r <= 1'b1;
        end else if (clear) begin
            first_r <= 1'b1;
        end else if (word_valid) begin
            first_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            max_val_r <= '0;
            max_pos_r <= '0;
        end else if (word_valid && take_max) begin
            max_val_r <= word;
            max_pos_r <= pos;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            min_val_r <= '0;
            min_pos_r <= '0;
        end else if (word_valid && take_min) begin
            min_val_r <= word;
            min_pos_r <= pos;
        end
    end

    // wide sum, no overflow for 64 words
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sum_r <= '0;
        end else if (clear) begin
            sum_r <= '0;
        end else if (word_valid) begin
            sum_r <= sum_r + word_ext;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    max_tie_keep_a: assert property (
        word_valid && !first_r && !clear && word == max_val_r |=> max_pos_r == $past(max_pos_r))
        else $error("maximum position moved on a tie");
    min_tie_keep_a: assert property (
        word_valid && !first_r && !clear && word == min_val_r |=> min_pos_r == $past(min_pos_r))
        else $error("minimum position moved on a tie");
    max_bound_a: assert property (
        word_valid && !clear |=> max_val_r >= $past(word))
        else $error("maximum below a scanned word");
    min_bound_a: assert property (
        word_valid && !clear |=> min_val_r <= $past(word))
        else $error("minimum above a scanned word");

endmodule : tsf_scan_unit

// ### tb/tsf_seq_model.sv
// sequencer stand-in: a word table that answers the core's table reads.
// assumes the core reads at most every second cycle, as it promises.
`timescale 1ns/10ps

module tsf_seq_model (
    // clock
    input  wire logic        core_clk,
    // table read port of the core
    input  wire logic        tbl_rd_req_r,
    input  wire logic [6:0]  tbl_rd_addr_r,
    output logic [15:0]      tbl_rd_data
);
    // word table, loaded by the bench while the core is idle
    logic [15:0] mem [0:127];

    // word lands the cycle after the strobe; otherwise the bus is scrambled
    // so that a late or early sample never meets a stale word
    initial tbl_rd_data = 16'h0000;
    always @(posedge core_clk) begin
        if (tbl_rd_req_r)
            tbl_rd_data <= mem[tbl_rd_addr_r];
        else
            tbl_rd_data <= ~tbl_rd_data;
    end
endmodule : tsf_seq_model

// ### tb/test_tsf_core.sv
// self-checking bench of the table statistics and lookup core.
// assumes the core, its package and the sequencer model beside it.
`timescale 1ns/10ps

module test_tsf_core;
    // clock, reset and request
    logic              core_clk;
    logic              rst_n;
    logic              req_valid;
    tsf_pkg::tsf_req_s req;
    // core outputs and table bus
    logic              busy_r;
    logic              tbl_rd_req_r;
    logic [6:0]        tbl_rd_addr_r;
    logic [15:0]       tbl_rd_data;
    logic              done_r;
    tsf_pkg::tsf_res_s res_r;
    // bookkeeping
    int                errors;
    int                n_tests;
    int                lat;
    int                cycles = 0;

    tsf_core i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .busy_r(busy_r), .tbl_rd_req_r(tbl_rd_req_r), .tbl_rd_addr_r(tbl_rd_addr_r),
        .tbl_rd_data(tbl_rd_data), .done_r(done_r), .res_r(res_r));

    tsf_seq_model i_seq (
        .core_clk(core_clk), .tbl_rd_req_r(tbl_rd_req_r),
        .tbl_rd_addr_r(tbl_rd_addr_r), .tbl_rd_data(tbl_rd_data));

    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp, input string what);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask : chk1

    // one instruction; returns just after done_r with lat = cycles from taking
    task automatic run_op(input logic [2:0] op, input logic cond, input logic dest,
                          input logic [6:0] n, input logic [15:0] x);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req       <= '{tsf_pkg::tsf_op_e'(op), cond, dest, n, x};
        @(posedge core_clk);
        req_valid <= 1'b0;
        req.x     <= ~x; // request is only valid in the taking cycle
        lat = 0;
        do begin
            @(posedge core_clk);
            #1;
            lat = lat + 1;
        end while (done_r !== 1'b1 && lat < 400);
    endtask : run_op

    // executed result: flags on, value, and position where it is written
    task automatic chk_res(input logic [15:0] val, input logic [15:0] pos, input logic wpos);
        chk1(res_r.out_cond, 1'b1, "out_cond");
        chk1(res_r.wr_value, 1'b1, "wr_value");
        chk1(res_r.wr_pos, wpos, "wr_pos");
        chk1(busy_r, 1'b0, "busy at done");
        chk16(res_r.value, val, "value");
        if (wpos)
            chk16(res_r.pos, pos, "pos");
    endtask : chk_res

    // signed table with tied extremes, zeros up to the full count
    task automatic load_stats();
        logic [15:0] t [6];
        t = '{16'h0005, 16'hFFF0, 16'h7FFF, 16'h8000, 16'h7FFF, 16'h8000};
        for (int i = 0; i < 128; i++)
            i_seq.mem[i] = (i < 6) ? t[i] : 16'h0000;
    endtask : load_stats

    // max and min: signed order, ties, counts 1, 6 and 64
    task automatic t_extremes();
        load_stats();
        run_op(3'h0, 1'b1, 1'b0, 7'h06, 16'h0000);
        chk_res(16'h7FFF, 16'h0002, 1'b1);
        chk16(16'(lat), 16'h000D, "max latency");
        run_op(3'h1, 1'b1, 1'b0, 7'h06, 16'h0000);
        chk_res(16'h8000, 16'h0003, 1'b1);
        run_op(3'h0, 1'b1, 1'b0, 7'h40, 16'h0000);
        chk_res(16'h7FFF, 16'h0002, 1'b1);
        chk16(16'(lat), 16'h0081, "max latency");
        run_op(3'h1, 1'b1, 1'b0, 7'h40, 16'h0000);
        chk_res(16'h8000, 16'h0003, 1'b1);
        run_op(3'h0, 1'b1, 1'b0, 7'h01, 16'h0000);
        chk_res(16'h0005, 16'h0000, 1'b1);
        run_op(3'h1, 1'b1, 1'b0, 7'h01, 16'h0000);
        chk_res(16'h0005, 16'h0000, 1'b1);
    endtask : t_extremes

    // index register destination drops the position
    task automatic t_index();
        run_op(3'h0, 1'b1, 1'b1, 7'h06, 16'h0000);
        chk_res(16'h7FFF, 16'h0000, 1'b0);
        run_op(3'h1, 1'b1, 1'b1, 7'h06, 16'h0000);
        chk_res(16'h8000, 16'h0000, 1'b0);
    endtask : t_index

    // mean of -13 over 6 and over 64: truncation toward zero, not floor
    task automatic t_average();
        run_op(3'h2, 1'b1, 1'b0, 7'h06, 16'h0000);
        chk_res(16'hFFFE, 16'h0000, 1'b0);
        run_op(3'h2, 1'b1, 1'b0, 7'h40, 16'h0000);
        chk_res(16'h0000, 16'h0000, 1'b0);
        run_op(3'h2, 1'b1, 1'b0, 7'h01, 16'h0000);
        chk_res(16'h0005, 16'h0000, 1'b0);
    endtask : t_average

    // four-pair curve: interpolation, breakpoint hit, both clamps
    task automatic t_lookup();
        logic [15:0] curve [8];
        logic [15:0] xs [7];
        logic [15:0] ys [7];
        curve = '{16'hF830, 16'hFF9C, 16'h0064, 16'h07D0,
                  16'hF8F8, 16'hFED4, 16'h012C, 16'h0708};
        xs = '{16'h05DC, 16'h0000, 16'hF830, 16'hF448, 16'h8000, 16'h0BB8, 16'h7FFF};
        ys = '{16'h057D, 16'h0000, 16'hF8F8, 16'hF8F8, 16'hF8F8, 16'h0708, 16'h0708};
        foreach (curve[i])
            i_seq.mem[i] = curve[i];
        foreach (xs[i]) begin
            run_op(3'h3, 1'b1, 1'b0, 7'h04, xs[i]);
            chk_res(ys[i], 16'h0000, 1'b0);
        end
    endtask : t_lookup

    // breakpoints at both ends of the range need a wide product
    task automatic t_range();
        logic [15:0] xs [3];
        i_seq.mem[0] = 16'h8000;
        i_seq.mem[1] = 16'h7FFF;
        i_seq.mem[2] = 16'h8000;
        i_seq.mem[3] = 16'h7FFF;
        xs = '{16'h4000, 16'h8000, 16'h7FFF};
        foreach (xs[i]) begin
            run_op(3'h3, 1'b1, 1'b0, 7'h02, xs[i]);
            chk_res(xs[i], 16'h0000, 1'b0);
        end
    endtask : t_range

    // magnitude including the saturating corner
    task automatic t_magnitude();
        logic [15:0] xs [4];
        logic [15:0] ys [4];
        xs = '{16'hFFFB, 16'h8000, 16'h0007, 16'h0000};
        ys = '{16'h0005, 16'h7FFF, 16'h0007, 16'h0000};
        foreach (xs[i]) begin
            run_op(3'h4, 1'b1, 1'b0, 7'h00, xs[i]);
            chk_res(ys[i], 16'h0000, 1'b0);
        end
        run_op(3'h4, 1'b1, 1'b0, 7'h00, 16'hFFFB);
        chk_res(16'h0005, 16'h0000, 1'b0);
        chk16(16'(lat), 16'h0001, "mag latency");
    endtask : t_magnitude

    // every operation with its condition off: nothing written, value kept
    task automatic t_cond_off();
        for (int i = 0; i < 5; i++) begin
            run_op(3'(i), 1'b0, 1'b0, 7'h06, 16'h8000);
            chk1(res_r.out_cond | res_r.wr_value | res_r.wr_pos, 1'b0, "off flags");
            chk16(res_r.value, 16'h0005, "off value");
            chk16(16'(lat), 16'h0001, "off latency");
            chk1(busy_r, 1'b0, "off busy");
        end
    endtask : t_cond_off

    // reset, then the scenarios in turn
    initial begin
        errors    = 0;
        n_tests   = 0;
        lat       = 0;
        rst_n     = 1'b0;
        req_valid = 1'b0;
        req       = '0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        t_extremes();
        t_index();
        t_average();
        t_lookup();
        t_range();
        t_magnitude();
        t_cond_off();
        tally_and_finish();
    end
endmodule : test_tsf_core
